//--- serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // core clock and line pins
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  // line pulled high between frames
  initial o_line = 1'b1;
  // send one frame, lsb first, optional ninth bit
  task automatic send(input logic [8:0] d, input int n, input logic stp, input int per);
    o_line <= 1'b0;
    repeat (per) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_line <= d[i];
      repeat (per) @(posedge i_clk);
    end
    o_line <= stp;
    repeat (per) @(posedge i_clk);
    o_line <= 1'b1;
    repeat (per) @(posedge i_clk);
  endtask
  // capture one frame, bit length measured on the start bit
  task automatic catch(output logic [8:0] d, input int n, output int per, output logic stp);
    d = 9'h000;
    per = 0;
    @(negedge i_line);
    while (i_line === 1'b0) begin
      @(posedge i_clk);
      #1;
      per++;
    end
    repeat (per / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      d[i] = i_line;
      repeat (per) @(posedge i_clk);
    end
    stp = i_line;
  endtask
endmodule // serial_peer
`default_nettype wire

//--- serial_port_control.sv
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module serial_port_control (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [serial_port_pkg::ADDR_W-1:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [serial_port_pkg::DATA_W-1:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [serial_port_pkg::DATA_W-1:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // interrupt
  output logic O_IRQ,
  // serial pins
  output logic O_TXD,
  input wire logic I_RXD,
  output logic O_RXD,
  output logic O_RXD_OE
);
  import serial_port_pkg::*;

  logic ap, dp_wr_reg, dp_wr_next, dp_rd_reg, dp_rd_next, hready_reg, hready_next;
  logic [7:0] dp_addr_reg, dp_addr_next;
  logic [31:0] hrdata_reg, hrdata_next, rd_mux;
  logic [7:0] ctrl_reg, ctrl_next, ctrl_view, pwr_reg, pwr_next, sw;
  logic fe_reg, fe_next, irq_reg, irq_next;
  logic [15:0] rate_reg, rate_next;
  logic [IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next, iclr;
  logic [1:0] mode;
  logic m0, fe_sel, ren, mpe, tx_go, defer;
  logic [PER_W-1:0] period, half;
  ser_state_e tx_state_reg, tx_state_next, rx_state_reg, rx_state_next;
  logic [PER_W-1:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic [2:0] tx_bit_reg, tx_bit_next, rx_bit_reg, rx_bit_next;
  logic [7:0] tx_shift_reg, tx_shift_next, rx_shift_reg, rx_shift_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic txd_reg, txd_next, rxd_o_reg, rxd_o_next, rxd_oe_reg, rxd_oe_next;
  logic rxd_meta_reg, rxd_sync_reg, rxd_prev_reg, cap9_reg, cap9_next;
  logic tick, rtick, tx_done_evt, rx_done_evt, fe_evt, rx9_load, rx9_val;

  // decoded control fields
  assign mode = {ctrl_reg[MODE_LO_BIT], ctrl_reg[MODE_HI_BIT]};
  assign m0 = (mode == 2'b00);
  assign fe_sel = pwr_reg[FESEL_BIT];
  assign ren = ctrl_reg[REN_BIT];
  assign mpe = ctrl_reg[MPE_BIT];
  assign tx_go = dp_wr_reg & (dp_addr_reg == BUF_OFS);
  assign ctrl_view = {fe_sel ? fe_reg : ctrl_reg[MODE_LO_BIT], ctrl_reg[6:0]};
  assign half = period >> 1;

  // bit period per mode and speed options
  always_comb begin
    case (mode)
      2'b00: period = M0_DIV;
      2'b10: period = M2_DIV;
      default: period = {1'b0, rate_reg, 1'b0} + 18'h00002;
    endcase
    if (pwr_reg[DBL_BIT] && !m0) period = period >> 1;
    if (pwr_reg[X2_BIT]) period = period >> 1;
    if (period == 18'h00000) period = 18'h00001;
  end

  // ahb-lite phases, reads take one wait state
  always_comb begin
    ap = I_HSEL & I_HREADY & I_HTRANS[1];
    dp_wr_next = ap & I_HWRITE;
    dp_rd_next = ap & ~I_HWRITE;
    dp_addr_next = ap ? I_HADDR : dp_addr_reg;
    hready_next = ~dp_rd_next;
    case (dp_addr_reg)
      CTRL_OFS: rd_mux = {24'h000000, ctrl_view};
      BUF_OFS: rd_mux = {24'h000000, rx_data_reg};
      PWR_OFS: rd_mux = {24'h000000, pwr_reg};
      RATE_OFS: rd_mux = {16'h0000, rate_reg};
      ISTAT_OFS: rd_mux = {29'h00000000, istat_reg};
      IMASK_OFS: rd_mux = {29'h00000000, imask_reg};
      default: rd_mux = 32'h00000000;
    endcase
    hrdata_next = dp_rd_reg ? rd_mux : hrdata_reg;
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
    end else begin
      dp_wr_reg <= dp_wr_next;
      dp_rd_reg <= dp_rd_next;
      dp_addr_reg <= dp_addr_next;
      hready_reg <= hready_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // software writes, then hardware events win
  always_comb begin
    sw = ctrl_view;
    if (dp_wr_reg && dp_addr_reg == CTRL_OFS) sw = I_HWDATA[7:0];
    if (dp_wr_reg && dp_addr_reg == CSET_OFS) sw = ctrl_view | I_HWDATA[7:0];
    if (dp_wr_reg && dp_addr_reg == CCLR_OFS) sw = ctrl_view & ~I_HWDATA[7:0];
    ctrl_next = {fe_sel ? ctrl_reg[MODE_LO_BIT] : sw[7], sw[6:0]};
    fe_next = fe_sel ? sw[7] : fe_reg;
    if (tx_done_evt) ctrl_next[TXDONE_BIT] = 1'b1;
    if (rx_done_evt) ctrl_next[RXDONE_BIT] = 1'b1;
    if (rx9_load) ctrl_next[RX9_BIT] = rx9_val;
    if (fe_evt) fe_next = 1'b1;
    pwr_next = pwr_reg;
    if (dp_wr_reg && dp_addr_reg == PWR_OFS) pwr_next = I_HWDATA[7:0];
    rate_next = rate_reg;
    if (dp_wr_reg && dp_addr_reg == RATE_OFS) rate_next = I_HWDATA[15:0];
    imask_next = imask_reg;
    if (dp_wr_reg && dp_addr_reg == IMASK_OFS) imask_next = I_HWDATA[IRQ_W-1:0];
    iclr = (dp_wr_reg && dp_addr_reg == ISTAT_OFS) ? I_HWDATA[IRQ_W-1:0] : 3'h0;
    istat_next = istat_reg & ~iclr;
    istat_next[IRQ_RX_BIT] = istat_next[IRQ_RX_BIT] | rx_done_evt;
    istat_next[IRQ_TX_BIT] = istat_next[IRQ_TX_BIT] | tx_done_evt;
    istat_next[IRQ_FE_BIT] = istat_next[IRQ_FE_BIT] | fe_evt;
    irq_next = |(istat_next & imask_next);
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_reg <= CTRL_RST;
      fe_reg <= 1'b0;
      pwr_reg <= PWR_RST;
      rate_reg <= RATE_RST;
      istat_reg <= 3'h0;
      imask_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      fe_reg <= fe_next;
      pwr_reg <= pwr_next;
      rate_reg <= rate_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      irq_reg <= irq_next;
    end
  end

  // transmit sequencer and pin drive
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    tx_done_evt = 1'b0;
    tick = (tx_cnt_reg == 18'h00000);
    if (tx_state_reg != ST_IDLE) tx_cnt_next = tick ? period - 18'h00001 : tx_cnt_reg - 18'h00001;
    case (tx_state_reg)
      ST_IDLE: begin
        if (tx_go) begin
          tx_shift_next = I_HWDATA[7:0];
          tx_bit_next = 3'h0;
          tx_cnt_next = period - 18'h00001;
          tx_state_next = m0 ? ST_DATA : ST_START;
        end
      end
      ST_START: if (tick) tx_state_next = ST_DATA;
      ST_DATA: begin
        if (tick) begin
          tx_shift_next = {1'b0, tx_shift_reg[7:1]};
          tx_bit_next = tx_bit_reg + 3'h1;
          if (tx_bit_reg == 3'h7) begin
            if (m0) begin
              tx_state_next = ST_IDLE;
              tx_done_evt = 1'b1;
            end else if (mode[1]) begin
              tx_state_next = ST_NINTH;
            end else begin
              tx_state_next = ST_STOP;
              tx_done_evt = 1'b1;
            end
          end
        end
      end
      ST_NINTH: begin
        if (tick) begin
          tx_state_next = ST_STOP;
          tx_done_evt = 1'b1;
        end
      end
      ST_STOP: if (tick) tx_state_next = ST_IDLE;
      default: tx_state_next = ST_IDLE;
    endcase
    txd_next = 1'b1;
    rxd_o_next = 1'b1;
    rxd_oe_next = 1'b0;
    case (tx_state_reg)
      ST_START: txd_next = 1'b0;
      ST_DATA: begin
        if (m0) begin
          txd_next = (tx_cnt_reg <= half); // shift clock, low first half
          rxd_o_next = tx_shift_reg[0];
          rxd_oe_next = 1'b1;
        end else begin
          txd_next = tx_shift_reg[0];
        end
      end
      ST_NINTH: txd_next = ctrl_reg[TX9_BIT];
      default: txd_next = 1'b1;
    endcase
    if (m0 && rx_state_reg == ST_DATA) txd_next = (rx_cnt_reg <= half);
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_state_reg <= ST_IDLE;
      tx_cnt_reg <= 18'h00000;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      txd_reg <= 1'b1;
      rxd_o_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      txd_reg <= txd_next;
      rxd_o_reg <= rxd_o_next;
      rxd_oe_reg <= rxd_oe_next;
    end
  end

  // receive sequencer, flag and ninth-bit events
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_data_next = rx_data_reg;
    cap9_next = cap9_reg;
    rx_done_evt = 1'b0;
    fe_evt = 1'b0;
    rx9_load = 1'b0;
    rx9_val = cap9_reg;
    rtick = (rx_cnt_reg == 18'h00000);
    defer = fe_sel | ((mode == 2'b01) & mpe);
    if (rx_state_reg != ST_IDLE) rx_cnt_next = rtick ? period - 18'h00001 : rx_cnt_reg - 18'h00001;
    case (rx_state_reg)
      ST_IDLE: begin
        rx_bit_next = 3'h0;
        rx_cnt_next = period - 18'h00001;
        if (m0 && !ctrl_reg[RXDONE_BIT] && tx_state_reg == ST_IDLE && !tx_go) begin
          rx_state_next = ST_DATA;
        end else if (!m0 && rxd_prev_reg && !rxd_sync_reg) begin
          rx_state_next = ST_START;
          rx_cnt_next = half;
        end
      end
      ST_START: if (rtick) rx_state_next = rxd_sync_reg ? ST_IDLE : ST_DATA;
      ST_DATA: begin
        if (rtick) begin
          rx_shift_next = {rxd_sync_reg, rx_shift_reg[7:1]};
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == 3'h7) begin
            if (m0) begin
              rx_state_next = ST_IDLE;
              rx_done_evt = 1'b1;
              rx_data_next = rx_shift_next;
            end else if (mode[1]) begin
              rx_state_next = ST_NINTH;
            end else begin
              rx_state_next = ST_STOP;
              rx_done_evt = ~defer;
              rx_data_next = defer ? rx_data_reg : rx_shift_next;
            end
          end
        end
      end
      ST_NINTH: begin
        if (rtick) begin
          cap9_next = rxd_sync_reg;
          rx_state_next = ST_STOP;
          if (!defer && (!mpe || rxd_sync_reg)) begin
            rx_done_evt = 1'b1;
            rx_data_next = rx_shift_reg;
            rx9_load = 1'b1;
            rx9_val = rxd_sync_reg;
          end
        end
      end
      ST_STOP: begin
        if (rtick) begin
          rx_state_next = ST_IDLE;
          fe_evt = ~rxd_sync_reg;
          if (mode == 2'b01 && !mpe) begin
            rx9_load = 1'b1;
            rx9_val = rxd_sync_reg;
          end
          if (defer && (!mpe || (mode[1] ? cap9_reg : rxd_sync_reg))) begin
            rx_done_evt = 1'b1;
            rx_data_next = rx_shift_reg;
            if (mode[1]) rx9_load = 1'b1;
          end
        end
      end
      default: rx_state_next = ST_IDLE;
    endcase
    if (!ren) rx_state_next = ST_IDLE;
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
      rx_state_reg <= ST_IDLE;
      rx_cnt_reg <= 18'h00000;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      cap9_reg <= 1'b0;
    end else begin
      rxd_meta_reg <= I_RXD;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_data_reg <= rx_data_next;
      cap9_reg <= cap9_next;
    end
  end

  // outputs straight from flops, except the response tied to okay
  assign O_HRDATA = hrdata_reg;
  assign O_HREADYOUT = hready_reg;
  assign O_HRESP = 1'b0; // always okay
  assign O_IRQ = irq_reg;
  assign O_TXD = txd_reg;
  assign O_RXD = rxd_o_reg;
  assign O_RXD_OE = rxd_oe_reg;
endmodule // serial_port_control
`default_nettype wire

//--- serial_port_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_control_monitor (
  // clock, reset and bus
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic [serial_port_pkg::DATA_W-1:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  // interrupt and pins
  input wire logic O_IRQ,
  input wire logic O_TXD,
  input wire logic O_RXD_OE
);
  // accepted transfers
  wire logic rd_tk = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE;
  wire logic wr_tk = I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // bus answer timing
  AST_RESP_OKAY: assert property (O_HRESP == 1'b0)
    else $error("response not okay");
  AST_READ_WAIT: assert property (rd_tk |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (wr_tk |=> O_HREADYOUT)
    else $error("write stalled");
  AST_WAIT_CAUSE: assert property (!O_HREADYOUT |-> $past(rd_tk))
    else $error("wait without read");
  AST_READY_PULSE: assert property (!O_HREADYOUT |=> O_HREADYOUT)
    else $error("wait longer than one cycle");
  AST_DATA_HOLD: assert property (!$stable(O_HRDATA) |-> !$past(O_HREADYOUT))
    else $error("read data moved outside a read");
  // interrupt only drops after a software write, outputs idle after reset
  AST_IRQ_CLEAR: assert property ($fell(O_IRQ) |-> $past(wr_tk, 2))
    else $error("interrupt dropped without a write");
  AST_RESET_IDLE: assert property ($rose(I_NRST) |-> O_TXD && !O_RXD_OE && !O_IRQ)
    else $error("outputs not idle after reset");
  // main scenarios
  COV_READ: cover property (rd_tk);
  COV_IRQ: cover property ($rose(O_IRQ));
  COV_SHIFT: cover property ($rose(O_RXD_OE));
endmodule // serial_port_control_monitor
bind serial_port_control serial_port_control_monitor u_mon (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
  .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_IRQ(O_IRQ),
  .O_TXD(O_TXD), .O_RXD_OE(O_RXD_OE));
`default_nettype wire

//--- serial_port_pkg.sv
package serial_port_pkg;
  // bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BUF_OFS = 8'h04;
  localparam logic [7:0] PWR_OFS = 8'h08;
  localparam logic [7:0] RATE_OFS = 8'h0C;
  localparam logic [7:0] ISTAT_OFS = 8'h10;
  localparam logic [7:0] IMASK_OFS = 8'h14;
  localparam logic [7:0] CSET_OFS = 8'h18;
  localparam logic [7:0] CCLR_OFS = 8'h1C;
  // serial_control_reg fields (bit 7 also frames framing_error_flag)
  localparam int MODE_LO_BIT = 7;
  localparam int MODE_HI_BIT = 6;
  localparam int MPE_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TX9_BIT = 3;
  localparam int RX9_BIT = 2;
  localparam int TXDONE_BIT = 1;
  localparam int RXDONE_BIT = 0;
  // power register fields
  localparam int DBL_BIT = 7;
  localparam int FESEL_BIT = 6;
  localparam int X2_BIT = 0;
  // interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_FE_BIT = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [15:0] RATE_RST = 16'h0000;
  // bit period timing, in core clocks
  localparam int PER_W = 18;
  localparam logic [PER_W-1:0] M0_DIV = 18'h0000C;
  localparam logic [PER_W-1:0] M2_DIV = 18'h00040;
  // shared frame sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} ser_state_e;
endpackage

//--- tb_serial_port_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_serial_port_control;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic nrst, hsel, hwrite, hready, irq, txd, line, sdo, sdo_oe;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  int compares = 0;
  int bad_count = 0;
  int cycles = 0;
  // 50 MHz core clock
  always #10 clk = ~clk;
  serial_port_control dut (.I_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(), .O_IRQ(irq),
    .O_TXD(txd), .I_RXD(line), .O_RXD(sdo), .O_RXD_OE(sdo_oe));
  serial_peer peer (.i_clk(clk), .i_line(txd), .o_line(line));
  // verdict and end of run
  task close_out();
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      close_out();
    end
  end
  // single word bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    `CHK(r, e)
  endtask
  // reset values, unmapped place, single bit set and clear
  task automatic t_regs();
    chk_rd(CTRL_OFS, 32'h0);
    chk_rd(PWR_OFS, 32'h0);
    wr(8'h20, 32'hFF);
    chk_rd(8'h20, 32'h0);
    wr(CSET_OFS, 32'h8);
    chk_rd(CTRL_OFS, 32'h8);
    wr(CCLR_OFS, 32'h8);
    chk_rd(CTRL_OFS, 32'h0);
  endtask
  // one transmitted frame, then interrupt mask and clear
  task automatic t_tx(input logic [7:0] c, input logic [7:0] p, input logic [7:0] d, input int e);
    logic [8:0] got;
    logic stp;
    int per;
    logic [31:0] r;
    wr(CTRL_OFS, {24'h0, c});
    wr(PWR_OFS, {24'h0, p});
    wr(IMASK_OFS, 32'h2);
    fork
      peer.catch(got, 9, per, stp);
      wr(BUF_OFS, {24'h0, d});
    join
    `CHK(per, e)
    `CHK(got, {c[3], d})
    `CHK(stp, 1'b1)
    `CHK(irq, 1'b1)
    wr(IMASK_OFS, 32'h0);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wr(ISTAT_OFS, 32'h7);
    wr(IMASK_OFS, 32'h2);
    @(posedge clk);
    `CHK(irq, 1'b0)
    rd(CTRL_OFS, r);
    `CHK(r[1], 1'b1)
    wr(CCLR_OFS, 32'h2);
    rd(CTRL_OFS, r);
    `CHK(r[1], 1'b0)
  endtask
  // multiprocessor filter in mode 3
  task automatic t_rx_mp();
    wr(PWR_OFS, 32'h0);
    wr(CTRL_OFS, 32'hF0);
    peer.send(9'h03C, 9, 1'b1, 8);
    chk_rd(CTRL_OFS, 32'hF0);
    peer.send(9'h15A, 9, 1'b1, 8);
    chk_rd(CTRL_OFS, 32'hF5);
    chk_rd(BUF_OFS, 32'h5A);
  endtask
  // framing error in mode 1
  task automatic t_fe();
    wr(CTRL_OFS, 32'h50);
    wr(PWR_OFS, 32'h40);
    peer.send(9'h081, 8, 1'b0, 8);
    chk_rd(CTRL_OFS, 32'hD1);
    wr(CCLR_OFS, 32'h1);
    peer.send(9'h0F0, 8, 1'b1, 8);
    chk_rd(CTRL_OFS, 32'hD5);
    wr(PWR_OFS, 32'h0);
    chk_rd(CTRL_OFS, 32'h55);
    wr(PWR_OFS, 32'h40);
    wr(CTRL_OFS, 32'h50);
    chk_rd(CTRL_OFS, 32'h50);
    wr(PWR_OFS, 32'h0);
    chk_rd(CTRL_OFS, 32'h50);
    // mode 1 with multiproc: bad stop bit frame dropped, good one taken
    wr(CTRL_OFS, 32'h70);
    peer.send(9'h0AA, 8, 1'b0, 8);
    chk_rd(CTRL_OFS, 32'h70);
    peer.send(9'h0C3, 8, 1'b1, 8);
    chk_rd(CTRL_OFS, 32'h71);
    chk_rd(BUF_OFS, 32'hC3);
  endtask
  // shift register mode, multiproc kept clear
  task automatic t_mode0();
    logic [7:0] sent;
    sent = 8'h96;
    wr(CTRL_OFS, 32'h4);
    wr(BUF_OFS, {24'h0, sent});
    // mid bit: data out, driver on, shift clock low; late half: clock high
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      `CHK(sdo, sent[i])
      `CHK(sdo_oe, 1'b1)
      `CHK(txd, 1'b0)
      if (i < 7) begin
        repeat (6) @(posedge clk);
        `CHK(txd, 1'b1)
        repeat (6) @(posedge clk);
      end
    end
    chk_rd(CTRL_OFS, 32'h4);
    repeat (20) @(posedge clk);
    chk_rd(CTRL_OFS, 32'h6);
    `CHK(sdo_oe, 1'b0)
    wr(CTRL_OFS, 32'h14);
    repeat (110) @(posedge clk);
    chk_rd(CTRL_OFS, 32'h15);
    chk_rd(BUF_OFS, 32'hFF);
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    wr(RATE_OFS, 32'h3);
    t_tx(8'hC8, 8'h00, 8'hA5, 8);
    t_tx(8'hC0, 8'h80, 8'h35, 4);
    t_tx(8'h88, 8'h81, 8'h0F, 16);
    t_rx_mp();
    t_fe();
    t_mode0();
    close_out();
  end
endmodule // tb_serial_port_control
`default_nettype wire
